// File: src/iqr_top.sv
// Global status, command and interrupt queue reporting with APB register access
//
// Contract
// - Transmitter reset command raises a transmit-pool-ready event for the channel.
// - Each channel event becomes a vector written to its channel/direction ring.
// - Action request reads channel configuration and performs requested DMA initialisation.
// - After configuration a vector is written to the configuration queue.
// - After configuration DMA moves transmit data through central transmit FIFO.
// - Test loop returns transmit data to receiver, then to host buffer.
// - Frame completion reports all-sent, frame-start, host-initiated and frame-indication events.
// - Pending channel 1 transmit interrupt reads as status 0200 0000.
// - Status holds rx1, tx1, config and action-acknowledge bits; all give 2220 0001.
// - Channel 1 transmit-pool-ready vector is 5200 1000.
// - Channel 1 all-sent vector is 5204 0000.
// - Channel 1 receive-frame-start vector is 1200 0040.
// - Channel 1 receive DMA host-initiated plus frame-indication vector is 1006 0000.
// - Transmit buffer completion posts DMA frame-indication vector to transmit queue.
// - Channel configuration accepts 0018 0000: all interrupts on, both DMA inits.
// - Registers sit in a 256-byte global window and 128-byte channel windows.
// - Second window accesses are forwarded to the 64 KByte local bus.
// - Rings hold 32 entries at reset queue length.
`timescale 1ns/1ps
`default_nettype none
`include "iqr_defs.svh"
module iqr_top
    import iqr_pkg::*;
#(
    parameter int DEPTH = `IQR_RING_DEPTH
)(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [16:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Local bus port
    output logic lb_valid,
    output logic lb_write,
    output logic [15:0] lb_addr,
    output logic [31:0] lb_wdata,
    input wire logic [31:0] lb_rdata,
    input wire logic lb_ready,
    // Serial channel and DMA events
    input wire logic ev_all_sent,
    input wire logic ev_rx_frame_start,
    input wire logic ev_tx_frame_done,
    input wire logic ev_rx_dma_done,
    // Serial channel and DMA control
    output logic serial_tx_reset,
    output logic test_loop,
    output logic init_rx_dma,
    output logic init_tx_dma,
    output logic tx_dma_run,
    output logic rx_dma_run,
    output logic [31:0] rx_desc_base,
    output logic [31:0] tx_desc_base,
    // Shared memory write port
    output logic mem_valid,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_data,
    input wire logic mem_ack
);
    iqr_state_t s_reg, s_next;
    iqr_vec_if vq [3] ();
    logic [2:0] w_valid, w_done, w_ack;
    logic [31:0] w_addr [3];
    logic [31:0] w_data [3];
    logic [31:0] q_base [3];
    logic sel_lb, acc, wr, rd, mapped;
    logic [10:0] ofs;
    logic [5:0] taken;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    // upper window to local bus
    assign sel_lb = paddr[`IQR_LB_SEL_BIT];
    assign acc = psel && penable;
    assign ofs = paddr[10:0];
    assign mapped = !sel_lb && paddr[15:11] == 5'h00 && ofs[1:0] == 2'b00 &&
        (ofs == `IQR_OFS_CMD || ofs == `IQR_OFS_STATUS || ofs == `IQR_OFS_CFGQ_BASE ||
        ofs == `IQR_OFS_RXQ_BASE || ofs == `IQR_OFS_TXQ_BASE || ofs == `IQR_OFS_CH1_CFG ||
        ofs == `IQR_OFS_CH1_RXDESC || ofs == `IQR_OFS_CH1_TXDESC ||
        ofs == `IQR_OFS_CH1_CMD || ofs == `IQR_OFS_CH1_MODE);
    assign wr = acc && pwrite && !sel_lb && mapped;
    assign rd = acc && !pwrite && !sel_lb;
    assign pready = sel_lb ? lb_ready : 1'b1;
    assign pslverr = acc && !sel_lb && !mapped;
    assign lb_valid = psel && sel_lb;
    assign lb_write = pwrite;
    assign lb_addr = paddr[15:0];
    assign lb_wdata = pwdata;

    always_comb
    begin
        prdata = `IQR_RST_WORD;
        if (sel_lb)
            prdata = lb_rdata;
        else if (rd)
        begin
            unique case (ofs)
                `IQR_OFS_CMD: prdata = s_reg.cmd;
                `IQR_OFS_STATUS: prdata = s_reg.status;
                `IQR_OFS_CFGQ_BASE: prdata = s_reg.cfgq_base;
                `IQR_OFS_RXQ_BASE: prdata = s_reg.rxq_base;
                `IQR_OFS_TXQ_BASE: prdata = s_reg.txq_base;
                `IQR_OFS_CH1_CFG: prdata = s_reg.ch_cfg;
                `IQR_OFS_CH1_RXDESC: prdata = s_reg.rx_desc;
                `IQR_OFS_CH1_TXDESC: prdata = s_reg.tx_desc;
                `IQR_OFS_CH1_MODE: prdata = {31'h0, s_reg.loop_en};
                default: prdata = `IQR_RST_WORD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector selection per queue (0 cfg, 1 rx, 2 tx)
    // transmit queue code: pool-ready first, then frame indication, then all-sent
    assign vq[2].valid = |s_reg.pend[5:3];
    assign vq[2].vector = s_reg.pend[5] ? `IQR_VEC_XPR :
        (s_reg.pend[4] ? `IQR_VEC_TX_FI : `IQR_VEC_ALL_SENT);
    assign vq[1].valid = |s_reg.pend[2:1];
    assign vq[1].vector = s_reg.pend[2] ? `IQR_VEC_RFS : `IQR_VEC_RX_HIFI;
    assign vq[0].valid = s_reg.pend[0];
    assign vq[0].vector = `IQR_VEC_CFG;

    always_comb
    begin
        taken = 6'h00;
        if (vq[2].valid && vq[2].ready)
            taken[5:3] = s_reg.pend[5] ? 3'b100 : (s_reg.pend[4] ? 3'b010 : 3'b001);
        if (vq[1].valid && vq[1].ready)
            taken[2:1] = s_reg.pend[2] ? 2'b10 : 2'b01;
        if (vq[0].valid && vq[0].ready)
            taken[0] = 1'b1;
    end

    assign q_base[0] = s_reg.cfgq_base;
    assign q_base[1] = s_reg.rxq_base;
    assign q_base[2] = s_reg.txq_base;

    for (genvar g = 0; g < 3; g++)
    begin : g_wr
        iqr_ring_writer #(.DEPTH(DEPTH)) u_wr (
            .pclk(pclk),
            .presetn(presetn),
            .base(q_base[g]),
            .vin(vq[g]),
            .mem_valid(w_valid[g]),
            .mem_addr(w_addr[g]),
            .mem_data(w_data[g]),
            .mem_ack(w_ack[g]),
            .done(w_done[g])
        );
        assign w_ack[g] = mem_ack && s_reg.grant_vld && s_reg.grant == 2'(g);
    end

    assign mem_valid = s_reg.grant_vld && w_valid[s_reg.grant];
    assign mem_addr = w_addr[s_reg.grant];
    assign mem_data = w_data[s_reg.grant];

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        s_next = s_reg;
        s_next.tx_reset = 1'b0;
        s_next.init_rx = 1'b0;
        s_next.init_tx = 1'b0;
        // Memory port grant held until ack, then dropped so an idle writer never keeps it
        if (!mem_valid)
        begin
            s_next.grant_vld = |w_valid;
            s_next.grant = w_valid[2] ? 2'd2 : (w_valid[1] ? 2'd1 : 2'd0);
        end
        else if (mem_ack)
            s_next.grant_vld = 1'b0;
        // host writes ones to clear status
        if (wr && ofs == `IQR_OFS_STATUS)
            s_next.status = s_reg.status & ~(pwdata & `IQR_ST_MASK);
        if (w_done[2])
            s_next.status[`IQR_ST_TX1_BIT] = 1'b1;
        if (w_done[1])
            s_next.status[`IQR_ST_RX1_BIT] = 1'b1;
        if (w_done[0])
        begin
            s_next.status[`IQR_ST_CFG_BIT] = 1'b1;
            s_next.status[`IQR_ST_ARACK_BIT] = 1'b1;
        end
        if (wr)
        begin
            unique case (ofs)
                `IQR_OFS_CMD: s_next.cmd = pwdata;
                `IQR_OFS_CFGQ_BASE: s_next.cfgq_base = pwdata;
                `IQR_OFS_RXQ_BASE: s_next.rxq_base = pwdata;
                `IQR_OFS_TXQ_BASE: s_next.txq_base = pwdata;
                `IQR_OFS_CH1_CFG: s_next.ch_cfg = pwdata;
                `IQR_OFS_CH1_RXDESC: s_next.rx_desc = pwdata;
                `IQR_OFS_CH1_TXDESC: s_next.tx_desc = pwdata;
                `IQR_OFS_CH1_MODE: s_next.loop_en = pwdata[`IQR_MODE_LOOP_BIT];
                default: s_next.cmd = s_reg.cmd;
            endcase
        end
        if (wr && ofs == `IQR_OFS_CH1_CMD && pwdata[`IQR_CH_TXRES_BIT])
            s_next.tx_reset = 1'b1;
        // event capture; only the two frame-indication events are gated by masks
        s_next.pend = (s_reg.pend & ~taken) | {s_reg.tx_reset,
            ev_tx_frame_done && !s_reg.ch_cfg[`IQR_CFG_MTFI_BIT],
            ev_all_sent, ev_rx_frame_start,
            ev_rx_dma_done && !s_reg.ch_cfg[`IQR_CFG_MRFI_BIT], 1'b0};
        unique case (s_reg.ar)
            AR_IDLE:
            begin
                if (wr && ofs == `IQR_OFS_CMD && pwdata[`IQR_CMD_AR_BIT])
                    s_next.ar = AR_CONFIG;
            end
            AR_CONFIG:
            begin
                s_next.init_rx = s_reg.ch_cfg[`IQR_CFG_IDR_BIT];
                s_next.init_tx = s_reg.ch_cfg[`IQR_CFG_IDT_BIT];
                if (s_reg.ch_cfg[`IQR_CFG_IDT_BIT])
                    s_next.tx_run = 1'b1;
                if (s_reg.ch_cfg[`IQR_CFG_IDR_BIT])
                    s_next.rx_run = 1'b1;
                s_next.pend[0] = 1'b1;
                s_next.ar = AR_POST;
            end
            AR_POST:
            begin
                if (w_done[0])
                    s_next.ar = AR_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign serial_tx_reset = s_reg.tx_reset;
    // loopback of transmit data to receiver
    assign test_loop = s_reg.loop_en;
    assign init_rx_dma = s_reg.init_rx;
    assign init_tx_dma = s_reg.init_tx;
    assign tx_dma_run = s_reg.tx_run;
    assign rx_dma_run = s_reg.rx_run;
    assign rx_desc_base = s_reg.rx_desc;
    assign tx_desc_base = s_reg.tx_desc;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_txres_xpr;
        @(posedge pclk) disable iff (!presetn)
        (wr && ofs == `IQR_OFS_CH1_CMD && pwdata[`IQR_CH_TXRES_BIT]) |=> ##1 s_reg.pend[5];
    endproperty
    a_txres_xpr: assert property (p_txres_xpr) else $error("no pool-ready after tx reset");
    property p_ar_cfg;
        @(posedge pclk) disable iff (!presetn)
        (s_reg.ar == AR_CONFIG && s_reg.ch_cfg[`IQR_CFG_IDT_BIT]) |=> init_tx_dma && tx_dma_run;
    endproperty
    a_ar_cfg: assert property (p_ar_cfg) else $error("tx DMA init missing");
    property p_cfg_vec;
        @(posedge pclk) disable iff (!presetn)
        s_reg.ar == AR_CONFIG |=> (vq[0].valid && vq[0].vector == 32'ha000_0001);
    endproperty
    a_cfg_vec: assert property (p_cfg_vec) else $error("config vector not posted");
    property p_tx_status;
        @(posedge pclk) disable iff (!presetn)
        w_done[2] |=> s_reg.status[`IQR_ST_TX1_BIT];
    endproperty
    a_tx_status: assert property (p_tx_status) else $error("tx1 status not set");
    property p_cfg_status;
        @(posedge pclk) disable iff (!presetn)
        w_done[0] |=> (s_reg.status & 32'h0020_0001) == 32'h0020_0001;
    endproperty
    a_cfg_status: assert property (p_cfg_status) else $error("cfg status not set");
    property p_xpr_code;
        @(posedge pclk) disable iff (!presetn)
        (vq[2].valid && s_reg.pend[5]) |-> vq[2].vector == 32'h5200_1000;
    endproperty
    a_xpr_code: assert property (p_xpr_code) else $error("pool-ready code wrong");
    property p_rfs_code;
        @(posedge pclk) disable iff (!presetn)
        (vq[1].valid && s_reg.pend[2]) |-> vq[1].vector == 32'h1200_0040;
    endproperty
    a_rfs_code: assert property (p_rfs_code) else $error("frame start code wrong");
    property p_lb_fwd;
        @(posedge pclk) disable iff (!presetn)
        (psel && paddr[`IQR_LB_SEL_BIT]) |-> lb_valid && lb_addr == paddr[15:0] &&
            pready == lb_ready;
    endproperty
    a_lb_fwd: assert property (p_lb_fwd) else $error("local bus not forwarded");
endmodule
`default_nettype wire

// File: common/iqr_defs.svh
// Offsets, field positions, reset values and vector codes of the queue reporting block
`ifndef IQR_DEFS_SVH
`define IQR_DEFS_SVH
`define IQR_LB_SEL_BIT 16
`define IQR_OFS_CMD 11'h000
`define IQR_OFS_STATUS 11'h004
`define IQR_OFS_CFGQ_BASE 11'h008
`define IQR_OFS_RXQ_BASE 11'h00c
`define IQR_OFS_TXQ_BASE 11'h010
`define IQR_OFS_CH1_CFG 11'h180
`define IQR_OFS_CH1_RXDESC 11'h184
`define IQR_OFS_CH1_TXDESC 11'h188
`define IQR_OFS_CH1_CMD 11'h18c
`define IQR_OFS_CH1_MODE 11'h190
`define IQR_CMD_AR_BIT 0
`define IQR_CH_TXRES_BIT 24
`define IQR_MODE_LOOP_BIT 0
`define IQR_CFG_IDR_BIT 20
`define IQR_CFG_IDT_BIT 19
`define IQR_CFG_MRFI_BIT 18
`define IQR_CFG_MTFI_BIT 17
`define IQR_CFG_MRERR_BIT 16
`define IQR_CFG_MTERR_BIT 15
`define IQR_ST_RX1_BIT 29
`define IQR_ST_TX1_BIT 25
`define IQR_ST_CFG_BIT 21
`define IQR_ST_ARACK_BIT 0
`define IQR_ST_MASK 32'h2220_0001
`define IQR_VEC_XPR 32'h5200_1000
`define IQR_VEC_ALL_SENT 32'h5204_0000
`define IQR_VEC_TX_FI 32'h5004_0000
`define IQR_VEC_RFS 32'h1200_0040
`define IQR_VEC_RX_HIFI 32'h1006_0000
`define IQR_VEC_CFG 32'ha000_0001
`define IQR_RST_WORD 32'h0000_0000
`define IQR_RING_DEPTH 32
`endif

// File: common/iqr_pkg.sv
// Types of the queue reporting block
package iqr_pkg;
    typedef enum logic [1:0] {AR_IDLE, AR_CONFIG, AR_POST} iqr_ar_t;
    typedef enum logic [0:0] {QW_IDLE, QW_BUSY} iqr_qw_t;
    // Pending event order: xpr, tx_fi, all_sent, rfs, rx_hifi, cfg
    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] status;
        logic [31:0] cfgq_base;
        logic [31:0] rxq_base;
        logic [31:0] txq_base;
        logic [31:0] ch_cfg;
        logic [31:0] rx_desc;
        logic [31:0] tx_desc;
        logic loop_en;
        logic tx_run;
        logic rx_run;
        logic tx_reset;
        logic init_rx;
        logic init_tx;
        logic [5:0] pend;
        logic [1:0] grant;
        logic grant_vld;
        iqr_ar_t ar;
    } iqr_state_t;
endpackage

// File: common/iqr_vec_if.sv
// Vector hand-over from event logic to one ring writer
`timescale 1ns/1ps
`default_nettype none
interface iqr_vec_if;
    logic valid;
    logic ready;
    logic [31:0] vector;
    modport src (output valid, output vector, input ready);
    modport snk (input valid, input vector, output ready);
endinterface
`default_nettype wire

// File: src/iqr_ring_writer.sv
// Ring buffer writer for one interrupt queue in shared memory
`timescale 1ns/1ps
`default_nettype none
`include "iqr_defs.svh"
module iqr_ring_writer
    import iqr_pkg::*;
#(
    parameter int DEPTH = `IQR_RING_DEPTH
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Ring base and vectors in
    input wire logic [31:0] base,
    iqr_vec_if.snk vin,
    // Memory write request
    output logic mem_valid,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_data,
    input wire logic mem_ack,
    output logic done
);
    localparam int IW = $clog2(DEPTH);
    typedef struct packed {
        iqr_qw_t st;
        logic [IW-1:0] idx;
        logic [31:0] addr;
        logic [31:0] data;
        logic done;
    } iqr_qw_state_t;
    iqr_qw_state_t s_reg, s_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            QW_IDLE:
            begin
                if (vin.valid)
                begin
                    s_next.st = QW_BUSY;
                    s_next.data = vin.vector;
                    s_next.addr = base + 32'({s_reg.idx, 2'b00});
                end
            end
            QW_BUSY:
            begin
                if (mem_ack)
                begin
                    s_next.st = QW_IDLE;
                    s_next.done = 1'b1;
                    s_next.idx = (s_reg.idx == IW'(DEPTH - 1)) ? '0 : s_reg.idx + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign vin.ready = (s_reg.st == QW_IDLE);
    assign mem_valid = (s_reg.st == QW_BUSY);
    assign mem_addr = s_reg.addr;
    assign mem_data = s_reg.data;
    assign done = s_reg.done;

    ////////////////////////////////////////////////////////////////////////
    property p_ring_wrap;
        @(posedge pclk) disable iff (!presetn)
        (mem_ack && mem_valid && s_reg.idx == IW'(DEPTH - 1)) |=> (s_reg.idx == '0);
    endproperty
    a_ring_wrap: assert property (p_ring_wrap) else $error("ring index did not wrap");
    property p_ring_step;
        @(posedge pclk) disable iff (!presetn)
        (vin.valid && vin.ready) |=> mem_valid && mem_addr == base + 32'({$past(s_reg.idx), 2'b00});
    endproperty
    a_ring_step: assert property (p_ring_step) else $error("entry address wrong");
endmodule
`default_nettype wire

// File: verification/iqr_mem_model.sv
// Shared memory and local bus model at the far side of the queue reporter
`timescale 1ns/1ps
`default_nettype none
module iqr_mem_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Response delays
    input wire logic [2:0] ack_dly,
    input wire logic [2:0] lb_dly,
    // Shared memory write port
    input wire logic mem_valid,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_data,
    output logic mem_ack,
    // Local bus port
    input wire logic lb_valid,
    input wire logic lb_write,
    input wire logic [15:0] lb_addr,
    input wire logic [31:0] lb_wdata,
    output logic [31:0] lb_rdata,
    output logic lb_ready
);
    int wr_cnt;
    logic [31:0] last_addr;
    logic [31:0] last_data;
    logic [31:0] lb_last;
    logic [2:0] mcnt;
    logic [2:0] lcnt;
    ////////////////////////////////////////////////////////////////////////////////
    // local bus data, inverted while not ready
    assign lb_rdata = lb_ready ? {16'ha5a5, lb_addr} : ~{16'ha5a5, lb_addr};
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack <= 1'b0;
            wr_cnt <= 0;
            mcnt <= 3'h0;
            last_addr <= 32'h0;
            last_data <= 32'h0;
        end
        else if (mem_valid && mem_ack)
        begin
            mem_ack <= 1'b0;
            mcnt <= 3'h0;
            wr_cnt <= wr_cnt + 1;
            last_addr <= mem_addr;
            last_data <= mem_data;
        end
        else if (mem_valid && mcnt >= ack_dly)
            mem_ack <= 1'b1;
        else if (mem_valid)
            mcnt <= mcnt + 3'h1;
    end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lb_ready <= 1'b0;
            lcnt <= 3'h0;
            lb_last <= 32'h0;
        end
        else
        begin
            lb_ready <= lb_valid && (lb_ready || lcnt >= lb_dly);
            lcnt <= lb_valid ? lcnt + 3'h1 : 3'h0;
            if (lb_valid && lb_ready && lb_write)
                lb_last <= lb_wdata;
        end
    end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench of the queue reporting block
`timescale 1ns/1ps
`default_nettype none
`include "iqr_defs.svh"
module tb_top;
    localparam int DEPTH = 32;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [16:0] paddr;
    logic [31:0] pwdata, prdata, lb_wdata, lb_rdata, rx_desc_base, tx_desc_base;
    logic [31:0] mem_addr, mem_data, rdv;
    logic lb_valid, lb_write, lb_ready, mem_valid, mem_ack;
    logic serial_tx_reset, test_loop, init_rx_dma, init_tx_dma, tx_dma_run, rx_dma_run;
    logic [15:0] lb_addr;
    logic [3:0] evs;
    logic [2:0] ack_dly, lb_dly;
    int n_mismatch, cmp_count, wcnt, ti, ri, cyc, n_txr, n_irx, n_itx, seed;
    iqr_top #(.DEPTH(DEPTH)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lb_valid(lb_valid), .lb_write(lb_write), .lb_addr(lb_addr), .lb_wdata(lb_wdata),
        .lb_rdata(lb_rdata), .lb_ready(lb_ready), .ev_all_sent(evs[0]),
        .ev_rx_frame_start(evs[1]), .ev_tx_frame_done(evs[2]), .ev_rx_dma_done(evs[3]),
        .serial_tx_reset(serial_tx_reset), .test_loop(test_loop), .init_rx_dma(init_rx_dma),
        .init_tx_dma(init_tx_dma), .tx_dma_run(tx_dma_run), .rx_dma_run(rx_dma_run),
        .rx_desc_base(rx_desc_base), .tx_desc_base(tx_desc_base), .mem_valid(mem_valid),
        .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack)
    );
    iqr_mem_model u_mem (
        .pclk(pclk), .presetn(presetn), .ack_dly(ack_dly), .lb_dly(lb_dly),
        .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack),
        .lb_valid(lb_valid), .lb_write(lb_write), .lb_addr(lb_addr), .lb_wdata(lb_wdata),
        .lb_rdata(lb_rdata), .lb_ready(lb_ready)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task conclude;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (serial_tx_reset === 1'b1)
            n_txr++;
        if (init_rx_dma === 1'b1)
            n_irx++;
        if (init_tx_dma === 1'b1)
            n_itx++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [16:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [10:0] o, input logic [31:0] d);
        apb(1'b1, {6'h0, o}, d);
    endtask
    task rd(input logic [10:0] o);
        apb(1'b0, {6'h0, o}, 32'h0);
    endtask
    task mw(input logic [31:0] a, input logic [31:0] d);
        int i;
        wcnt++;
        for (i = 0; i < 300 && u_mem.wr_cnt != wcnt; i++)
            @(posedge pclk);
        chk(u_mem.wr_cnt, wcnt);
        chk(u_mem.last_addr, a);
        chk(u_mem.last_data, d);
    endtask
    function logic [31:0] vec(input int e);
        case (e)
            0: return 32'h5204_0000;
            1: return 32'h1200_0040;
            2: return `IQR_VEC_TX_FI;
            default: return 32'h1006_0000;
        endcase
    endfunction
    function logic [31:0] qaddr(input logic [31:0] b, input int i);
        return b + 32'(4 * (i % DEPTH));
    endfunction
    task evk(input int e);
        logic tx;
        tx = (e == 0 || e == 2);
        @(posedge pclk);
        evs <= 4'h1 << e;
        @(posedge pclk);
        evs <= 4'h0;
        if (tx)
            mw(qaddr(32'h4000, ti), vec(e));
        else
            mw(qaddr(32'h2000, ri), vec(e));
        if (tx)
            ti++;
        else
            ri++;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 75862;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 17'h0;
        pwdata = 32'h0;
        evs = 4'h0;
        ack_dly = 3'h0;
        lb_dly = 3'h1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IQR_OFS_STATUS);
        chk(rdv, 32'h0); // status clear after reset
        chk({30'h0, tx_dma_run, rx_dma_run}, 32'h0); // no transfer before request
        wr(`IQR_OFS_CH1_RXDESC, 32'h0001_0000); // receive base first
        wr(`IQR_OFS_CH1_TXDESC, 32'h0001_1000); // transmit base first
        rd(`IQR_OFS_CH1_RXDESC);
        chk(rdv, 32'h0001_0000); // channel window read
        chk(rx_desc_base, 32'h0001_0000); // channel window
        chk(tx_desc_base, 32'h0001_1000); // channel window
        rd(11'h0fc);
        chk({31'h0, err}, 32'h1); // outside used registers
        chk(rdv, 32'h0); // outside used registers
        wr(`IQR_OFS_RXQ_BASE, 32'h0000_2000);
        wr(`IQR_OFS_TXQ_BASE, 32'h0000_4000);
        wr(`IQR_OFS_CFGQ_BASE, 32'h0000_6000);
        wr(`IQR_OFS_CH1_MODE, 32'h1);
        rd(`IQR_OFS_CH1_MODE);
        chk({31'h0, test_loop}, 32'h1); // loop mode
        wr(`IQR_OFS_CH1_CMD, 32'h0100_0000);
        mw(32'h4000, 32'h5200_1000); // pool ready vector
        chk(n_txr, 1); // transmitter reset
        ti = 1;
        rd(`IQR_OFS_STATUS);
        chk(rdv, 32'h0200_0000); // transmit pending
        wr(`IQR_OFS_STATUS, rdv); // host write back
        rd(`IQR_OFS_STATUS);
        chk(rdv, 32'h0); // cleared by ones
        wr(`IQR_OFS_CH1_CFG, 32'h0018_0000);
        rd(`IQR_OFS_CH1_CFG);
        chk(rdv, 32'h0018_0000); // value accepted
        wr(`IQR_OFS_CMD, 32'h1);
        mw(32'h6000, 32'ha000_0001); // configuration vector
        chk(n_irx, 1); // receive init
        chk(n_itx, 1); // transmit init
        chk({30'h0, tx_dma_run, rx_dma_run}, 32'h3); // transfer running
        rd(`IQR_OFS_STATUS);
        chk(rdv, 32'h0020_0001); // config and acknowledge bits
        wr(`IQR_OFS_STATUS, rdv);
        wr(`IQR_OFS_CMD, 32'h1);
        mw(32'h6004, 32'ha000_0001); // second config entry
        evk(2); // transmit buffer done
        evk(0); // all sent
        evk(1); // frame start
        evk(3); // receive dma vector
        rd(`IQR_OFS_STATUS);
        chk(rdv, 32'h2220_0001); // all four bits
        wr(`IQR_OFS_STATUS, rdv);
        rd(`IQR_OFS_STATUS);
        chk(rdv, 32'h0); // all cleared
        lb_dly <= 3'h3;
        apb(1'b1, 17'h1_0abc, 32'h1234_5678);
        @(posedge pclk);
        chk(u_mem.lb_last, 32'h1234_5678); // forwarded write
        apb(1'b0, 17'h1_0abc, 32'h0);
        chk(rdv, 32'ha5a5_0abc); // forwarded read
        repeat (70)
        begin
            ack_dly <= 3'($random(seed));
            evk($random(seed) & 3); // ring wrap
        end
        conclude();
    end
endmodule
`default_nettype wire
